// ---- nrbt_pkg.sv ----
// Shared constants and types for the digit rotate and bit test datapath
package nrbt_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_INSTR = 8'h08;
  localparam logic [7:0] REG_AF    = 8'h0c;
  localparam logic [7:0] REG_BC    = 8'h10;
  localparam logic [7:0] REG_DE    = 8'h14;
  localparam logic [7:0] REG_PTR   = 8'h18;
  localparam logic [7:0] REG_IDX1  = 8'h1c;
  localparam logic [7:0] REG_IDX2  = 8'h20;

  // Field positions
  localparam int CTRL_START   = 0;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_ILL     = 2;
  localparam int STAT_CNT_LSB = 8;

  // Opcode bytes and fields
  localparam logic [7:0] OPC_EXT    = 8'hed;
  localparam logic [7:0] OPC_ROT_L  = 8'h6f;
  localparam logic [7:0] OPC_ROT_R  = 8'h67;
  localparam logic [7:0] OPC_BITPFX = 8'hcb;
  localparam logic [7:0] OPC_IDX1   = 8'hdd;
  localparam logic [7:0] OPC_IDX2   = 8'hfd;
  localparam logic [1:0] BIT_GROUP  = 2'b01;
  localparam logic [2:0] RSEL_MEM   = 3'b110;

  // Clock states per instruction; one clock state is one aclk period
  localparam logic [4:0] T_ROT_TOTAL  = 5'h12;
  localparam logic [4:0] T_ROT_RD     = 5'h08;
  localparam logic [4:0] T_ROT_WR     = 5'h0f;
  localparam logic [4:0] T_BREG_TOTAL = 5'h08;
  localparam logic [4:0] T_BHL_TOTAL  = 5'h0c;
  localparam logic [4:0] T_BHL_RD     = 5'h08;
  localparam logic [4:0] T_BIDX_TOTAL = 5'h14;
  localparam logic [4:0] T_BIDX_RD    = 5'h0f;
  localparam logic [4:0] T_RD_LAT     = 5'h02;

  // Fixed values for the flags a bit test leaves undefined
  localparam logic BIT_S_FIXED  = 1'h0;
  localparam logic BIT_PV_FIXED = 1'h0;

  // Reset values and bus answers
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_PAIR    = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_RLD  = 3'b001,
    K_RRD  = 3'b010,
    K_BREG = 3'b011,
    K_BHL  = 3'b100,
    K_BIDX = 3'b101,
    K_ILL  = 3'b110
  } nrbt_kind_t;

  typedef struct packed {
    logic s;
    logic z;
    logic f5;
    logic h;
    logic f3;
    logic pv;
    logic n;
    logic c;
  } nrbt_flags_t;

  typedef struct packed {
    nrbt_kind_t kind;
    logic [2:0] bsel;
    logic [2:0] rsel;
    logic [7:0] disp;
    logic       use_idx2;
  } nrbt_op_t;

endpackage : nrbt_pkg

// ---- nrbt_alu.sv ----
// Result and flag logic for digit rotates and bit tests
module nrbt_alu
  import nrbt_pkg::*;
(
  // Operation
  input  wire nrbt_kind_t  kind,
  input  wire logic [2:0]  bsel,
  // Operands
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  mem,
  input  wire logic [7:0]  opnd,
  input  wire nrbt_flags_t flags_in,
  // Results
  output logic [7:0]       acc_out,
  output logic [7:0]       mem_out,
  output nrbt_flags_t      flags_out
);

  // Nibble exchange, then flags from the new accumulator; bit tests take zero from the chosen operand bit
  always_comb
  begin
    acc_out   = acc;
    mem_out   = mem;
    flags_out = flags_in;
    unique case (kind)
      K_RLD, K_RRD:
      begin
        if (kind == K_RLD)
        begin
          mem_out = {mem[3:0], acc[3:0]};
          acc_out = {acc[7:4], mem[7:4]};
        end
        else
        begin
          acc_out = {acc[7:4], mem[3:0]};
          mem_out = {acc[3:0], mem[7:4]};
        end
        flags_out.s  = acc_out[7];
        flags_out.z  = (acc_out == RST_BYTE);
        flags_out.pv = ~^acc_out;
        flags_out.h  = 1'b0;
        flags_out.n  = 1'b0;
      end
      K_BREG, K_BHL, K_BIDX:
      begin
        flags_out.z  = ~opnd[bsel];
        flags_out.h  = 1'b1;
        flags_out.n  = 1'b0;
        flags_out.s  = BIT_S_FIXED;
        flags_out.pv = BIT_PV_FIXED;
      end
      default:
      begin
        // No-op for idle or refused codes
      end
    endcase
  end

endmodule : nrbt_alu

// ---- nrbt_core.sv ----
// Digit rotate and bit test execution unit with AXI4-Lite register access
// Notes on behaviour
// - Left rotate: mem low to mem high, mem high to acc low, acc low to mem low.
// - Right rotate is ED 67; acc low nibble takes memory low nibble at pointer pair.
// - Right rotate: old acc low to mem high, mem high to mem low; acc high kept.
// - Each digit rotate lasts 18 clock states in five machine cycles.
// - After a rotate, sign follows accumulator bit 7.
// - After a rotate, zero is set when the accumulator is zero.
// - After a rotate, parity flag shows even parity; half and subtract clear; carry kept.
// - Register bit test is CB, 01 bbb rrr; 8 clock states.
// - Register field B..L as 000..101, accumulator 111; bit field selects bits 0..7.
// - Every bit test sets zero when the chosen bit is 0, else clears it.
// - Bit test sets half carry, clears subtract, keeps carry; sign and parity undefined.
// - Pointer bit test is CB, 01 bbb 110; reads memory, 12 clock states.
// - First index bit test DD CB d op; address index plus signed d; 20 states.
// - Second index bit test uses prefix FD and the second index pair.
// - A bit test writes only flags, never the register or memory byte.
module nrbt_core
  import nrbt_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Memory port, synchronous memory on aclk
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  // Status
  output logic             busy
);

  typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} nrbt_state_t;

  nrbt_state_t state_q, state_d;
  nrbt_op_t    op_q, op_d, dec;
  nrbt_flags_t flags_q, flags_d, alu_flags;
  logic [7:0]  acc_q, acc_d, mdata_q, mdata_d, alu_acc, alu_mem, opnd;
  logic [15:0] bc_q, bc_d, de_q, de_d, ptr_q, ptr_d;
  logic [15:0] idx1_q, idx1_d, idx2_q, idx2_d, addr_q, addr_d, idx_addr;
  logic [31:0] instr_q, instr_d, wmerge;
  logic [4:0]  t_q, t_d, last_t_q, last_t_d, tot, rd_at, wr_at;
  logic        rd_use, wr_use, done_q, done_d, ill_q, ill_d, commit, start;
  logic        mem_rd_q, mem_rd_d, mem_wr_q, mem_wr_d;
  logic [15:0] mem_addr_q, mem_addr_d;
  logic [7:0]  mem_wdata_q, mem_wdata_d;
  logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, wr_fire;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d, rd_word;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;

  // Opcode decode from the instruction word, first byte in the low lane
  function automatic nrbt_op_t decode(input logic [31:0] w);
    nrbt_op_t o;
    o      = '0;
    o.kind = K_ILL;
    if (w[7:0] == OPC_EXT)
    begin
      if (w[15:8] == OPC_ROT_L)
        o.kind = K_RLD;
      else if (w[15:8] == OPC_ROT_R)
        o.kind = K_RRD;
    end
    else if (w[7:0] == OPC_BITPFX && w[15:14] == BIT_GROUP)
    begin
      o.bsel = w[13:11];
      o.rsel = w[10:8];
      o.kind = (w[10:8] == RSEL_MEM) ? K_BHL : K_BREG;
    end
    else if ((w[7:0] == OPC_IDX1 || w[7:0] == OPC_IDX2) && w[15:8] == OPC_BITPFX &&
             w[31:30] == BIT_GROUP && w[26:24] == RSEL_MEM)
    begin
      o.kind     = K_BIDX;
      o.bsel     = w[29:27];
      o.rsel     = RSEL_MEM;
      o.disp     = w[23:16];
      o.use_idx2 = (w[7:0] == OPC_IDX2);
    end
    return o;
  endfunction : decode

  // Byte-lane merge for strobed writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction : merge

  // Timing plan per instruction kind
  always_comb
  begin
    tot    = T_BREG_TOTAL;
    rd_at  = T_ROT_RD;
    wr_at  = T_ROT_WR;
    rd_use = 1'b0;
    wr_use = 1'b0;
    unique case (op_q.kind)
      K_RLD, K_RRD:
      begin
        tot    = T_ROT_TOTAL;
        rd_at  = T_ROT_RD;
        wr_at  = T_ROT_WR;
        rd_use = 1'b1;
        wr_use = 1'b1;
      end
      K_BHL:
      begin
        tot    = T_BHL_TOTAL;
        rd_at  = T_BHL_RD;
        rd_use = 1'b1;
      end
      K_BIDX:
      begin
        tot    = T_BIDX_TOTAL;
        rd_at  = T_BIDX_RD;
        rd_use = 1'b1;
      end
      K_BREG:
        tot = T_BREG_TOTAL;
      default:
        tot = T_BREG_TOTAL;
    endcase
  end

  // Operand select; code 110 is the fetched memory byte
  always_comb
  begin
    unique case (op_q.rsel)
      3'b000: opnd = bc_q[15:8];
      3'b001: opnd = bc_q[7:0];
      3'b010: opnd = de_q[15:8];
      3'b011: opnd = de_q[7:0];
      3'b100: opnd = ptr_q[15:8];
      3'b101: opnd = ptr_q[7:0];
      3'b110: opnd = mdata_q;
      3'b111: opnd = acc_q;
    endcase
  end

  nrbt_alu u_alu (
    .kind      (op_q.kind),
    .bsel      (op_q.bsel),
    .acc       (acc_q),
    .mem       (mdata_q),
    .opnd      (opnd),
    .flags_in  (flags_q),
    .acc_out   (alu_acc),
    .mem_out   (alu_mem),
    .flags_out (alu_flags)
  );

  assign dec      = decode(instr_q);
  assign idx_addr = (dec.use_idx2 ? idx2_q : idx1_q) + {{8{dec.disp[7]}}, dec.disp};
  assign commit   = (state_q == ST_RUN) && (t_q == tot - 5'h01);
  assign start    = (state_q == ST_IDLE) && wr_fire && aw_addr_q == REG_CTRL &&
                    w_strb_q[0] && w_data_q[CTRL_START];
  assign wmerge   = merge(rd_word, w_data_q, w_strb_q);

  // Execution sequencer; software writes land only while idle
  always_comb
  begin
    state_d     = state_q;
    op_d        = op_q;
    flags_d     = flags_q;
    acc_d       = acc_q;
    bc_d        = bc_q;
    de_d        = de_q;
    ptr_d       = ptr_q;
    idx1_d      = idx1_q;
    idx2_d      = idx2_q;
    instr_d     = instr_q;
    addr_d      = addr_q;
    mdata_d     = mdata_q;
    t_d         = t_q;
    last_t_d    = last_t_q;
    done_d      = done_q;
    ill_d       = ill_q;
    mem_rd_d    = 1'b0;
    mem_wr_d    = 1'b0;
    mem_addr_d  = mem_addr_q;
    mem_wdata_d = mem_wdata_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (start)
        begin
          op_d   = dec;
          t_d    = 5'h00;
          done_d = 1'b0;
          ill_d  = 1'b0;
          addr_d = (dec.kind == K_BIDX) ? idx_addr : ptr_q;
          if (dec.kind == K_ILL)
          begin
            // Refused code finishes at once and touches nothing
            ill_d  = 1'b1;
            done_d = 1'b1;
          end
          else
            state_d = ST_RUN;
        end
        else if (wr_fire)
        begin
          case (aw_addr_q)
            REG_INSTR: instr_d = wmerge;
            REG_AF:
            begin
              acc_d   = wmerge[15:8];
              flags_d = nrbt_flags_t'(wmerge[7:0]);
            end
            REG_BC:   bc_d   = wmerge[15:0];
            REG_DE:   de_d   = wmerge[15:0];
            REG_PTR:  ptr_d  = wmerge[15:0];
            REG_IDX1: idx1_d = wmerge[15:0];
            REG_IDX2: idx2_d = wmerge[15:0];
            default:  instr_d = instr_q;
          endcase
        end
      end
      ST_RUN:
      begin
        t_d = t_q + 5'h01;
        if (rd_use && t_q == rd_at)
        begin
          mem_rd_d   = 1'b1;
          mem_addr_d = addr_q;
        end
        if (rd_use && t_q == rd_at + T_RD_LAT)
          mdata_d = mem_rdata;
        // Only rotates write back; bit tests never drive a write
        if (wr_use && t_q == wr_at)
        begin
          mem_wr_d    = 1'b1;
          mem_addr_d  = addr_q;
          mem_wdata_d = alu_mem;
        end
        if (commit)
        begin
          acc_d    = alu_acc;
          flags_d  = alu_flags;
          last_t_d = tot;
          done_d   = 1'b1;
          state_d  = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q     <= ST_IDLE;
      op_q        <= '0;
      flags_q     <= '0;
      acc_q       <= RST_BYTE;
      bc_q        <= RST_PAIR;
      de_q        <= RST_PAIR;
      ptr_q       <= RST_PAIR;
      idx1_q      <= RST_PAIR;
      idx2_q      <= RST_PAIR;
      instr_q     <= '0;
      addr_q      <= RST_PAIR;
      mdata_q     <= RST_BYTE;
      t_q         <= 5'h00;
      last_t_q    <= 5'h00;
      done_q      <= 1'b0;
      ill_q       <= 1'b0;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_addr_q  <= RST_PAIR;
      mem_wdata_q <= RST_BYTE;
    end
    else
    begin
      state_q     <= state_d;
      op_q        <= op_d;
      flags_q     <= flags_d;
      acc_q       <= acc_d;
      bc_q        <= bc_d;
      de_q        <= de_d;
      ptr_q       <= ptr_d;
      idx1_q      <= idx1_d;
      idx2_q      <= idx2_d;
      instr_q     <= instr_d;
      addr_q      <= addr_d;
      mdata_q     <= mdata_d;
      t_q         <= t_d;
      last_t_q    <= last_t_d;
      done_q      <= done_d;
      ill_q       <= ill_d;
      mem_rd_q    <= mem_rd_d;
      mem_wr_q    <= mem_wr_d;
      mem_addr_q  <= mem_addr_d;
      mem_wdata_q <= mem_wdata_d;
    end
  end

  // Register read view; a firing write borrows it for its byte merge, so reads wait that cycle
  always_comb
  begin
    rd_word = '0;
    unique case (wr_fire ? aw_addr_q : s_axi_araddr)
      REG_STAT:
      begin
        rd_word[STAT_BUSY]             = busy;
        rd_word[STAT_DONE]             = done_q;
        rd_word[STAT_ILL]              = ill_q;
        rd_word[STAT_CNT_LSB +: 5]     = last_t_q;
      end
      REG_INSTR: rd_word = instr_q;
      REG_AF:    rd_word[15:0] = {acc_q, flags_q};
      REG_BC:    rd_word[15:0] = bc_q;
      REG_DE:    rd_word[15:0] = de_q;
      REG_PTR:   rd_word[15:0] = ptr_q;
      REG_IDX1:  rd_word[15:0] = idx1_q;
      REG_IDX2:  rd_word[15:0] = idx2_q;
      default:   rd_word = '0;
    endcase
  end

  // AXI4-Lite slave: address and data taken in either order, one write and one read
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;

  always_comb
  begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d  = w_hold_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q && !s_axi_bready;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q && !s_axi_rready;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (s_axi_awvalid && !aw_hold_q)
    begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_q)
    begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (aw_addr_q <= REG_IDX2 && aw_addr_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end
    // A read waits one cycle behind a write decision, since both share the view mux
    if (s_axi_arvalid && !rvalid_q && !wr_fire)
    begin
      rvalid_d = 1'b1;
      rdata_d  = rd_word;
      rresp_d  = (s_axi_araddr <= REG_IDX2 && s_axi_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q  <= w_hold_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // Port drive
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready  = !w_hold_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q && !wr_fire;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign mem_rd        = mem_rd_q;
  assign mem_wr        = mem_wr_q;
  assign mem_addr      = mem_addr_q;
  assign mem_wdata     = mem_wdata_q;
  assign busy          = (state_q == ST_RUN);

  // Helpers read only by the checks below
  logic        cy, tbit;
  logic [7:0]  rrd_exp;
  assign cy      = flags_q.c;
  assign tbit    = opnd[op_q.bsel];
  assign rrd_exp = {acc_q[7:4], mdata_q[3:0]};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rot_length: assert property ($rose(busy) && op_q.kind inside {K_RLD, K_RRD} |-> ##17 commit ##1 !busy)
    else $error("digit rotate did not end after 18 states");
  a_breg_length: assert property ($rose(busy) && op_q.kind == K_BREG |-> ##7 commit ##1 !busy)
    else $error("register bit test did not end after 8 states");
  a_bhl_length: assert property ($rose(busy) && op_q.kind == K_BHL |-> ##11 commit ##1 !busy)
    else $error("pointer bit test did not end after 12 states");
  a_bidx_length: assert property ($rose(busy) && op_q.kind == K_BIDX |-> ##19 commit ##1 !busy)
    else $error("index bit test did not end after 20 states");
  a_rld_wdata: assert property (mem_wr && op_q.kind == K_RLD |-> mem_wdata == {mdata_q[3:0], acc_q[3:0]})
    else $error("left rotate wrote wrong memory byte");
  a_rrd_result: assert property (commit && op_q.kind == K_RRD |=> acc_q == $past(rrd_exp))
    else $error("right rotate accumulator wrong");
  a_rrd_wdata: assert property (mem_wr && op_q.kind == K_RRD |-> mem_wdata == {acc_q[3:0], mdata_q[7:4]})
    else $error("right rotate wrote wrong memory byte");
  a_rot_flags: assert property (commit && op_q.kind inside {K_RLD, K_RRD} |=>
                                flags_q.s == acc_q[7] && flags_q.z == (acc_q == 8'h00) &&
                                flags_q.pv == ~^acc_q && !flags_q.h && !flags_q.n && flags_q.c == $past(cy))
    else $error("rotate flags wrong");
  a_bit_zero: assert property (commit && op_q.kind inside {K_BREG, K_BHL, K_BIDX} |=>
                               flags_q.z != $past(tbit) && flags_q.h && !flags_q.n && flags_q.c == $past(cy))
    else $error("bit test flags wrong");
  a_bit_fixed: assert property (commit && op_q.kind inside {K_BREG, K_BHL, K_BIDX} |=>
                                flags_q.s == BIT_S_FIXED && flags_q.pv == BIT_PV_FIXED)
    else $error("undefined bit test flags not fixed");
  a_bit_no_store: assert property (busy && op_q.kind inside {K_BREG, K_BHL, K_BIDX} |-> ##1 !mem_wr && $stable(acc_q))
    else $error("bit test changed a register or memory");
  a_idx_address: assert property ($rose(mem_rd) && op_q.kind == K_BIDX |->
                                  mem_addr == (op_q.use_idx2 ? idx2_q : idx1_q) + {{8{op_q.disp[7]}}, op_q.disp})
    else $error("index address wrong");

  c_rld: cover property (commit && op_q.kind == K_RLD);
  c_rrd: cover property (commit && op_q.kind == K_RRD);
  c_idx2: cover property (commit && op_q.kind == K_BIDX && op_q.use_idx2);
  c_ill: cover property (ill_q && done_q);

endmodule : nrbt_core

// ---- nrbt_mem_model.sv ----
// Byte memory model on the far side of the core's memory port
module nrbt_mem_model
(
  // Clock
  input  wire logic        aclk,
  // Memory port
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata
);
  timeunit 1ns / 1ps;
  logic [7:0] mem [0:65535];
  int         wr_count = 0;
  // Data follows the strobe by one edge; otherwise it toggles so a stale byte never looks valid
  always @(posedge aclk)
  begin
    if (mem_wr)
    begin
      mem[mem_addr] <= mem_wdata;
      wr_count      <= wr_count + 1;
    end
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
  end
  initial mem_rdata = 8'h00;
endmodule : nrbt_mem_model

// ---- testbench.sv ----
// Self-checking bench for the digit rotate and bit test core
module testbench
  import nrbt_pkg::*;
();
  timeunit 1ns / 1ps;
  logic        aclk, aresetn, busy, mem_rd, mem_wr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, mem_wdata, mem_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] mem_addr;
  int          miscompares, samples_checked, cycles, wc;
  // Operand per register code; code 110 is the byte at the pointer pair
  logic [7:0]  opnd [8] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h50, 8'h00, 8'h69, 8'h96};

  nrbt_core u_nrbt_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_rd,
    .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .busy);
  nrbt_mem_model u_nrbt_mem_model (.aclk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);

  always #12.5 aclk = ~aclk;

  // Hang guard, well above the fewer than two thousand cycles the tests need
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Write: address and data each released when taken, bready held until the response
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit ha = 1'b0;
    bit hw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ha && hw))
    begin
      @(posedge aclk);
      ha |= s_axi_awready;
      hw |= s_axi_wready;
      s_axi_awvalid <= !ha;
      s_axi_wvalid  <= !hw;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d   = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Start one instruction and time its busy window against the state count
  task automatic run(input logic [31:0] ins, input logic [4:0] t);
    int n = 0;
    wr(REG_INSTR, ins);
    wr(REG_CTRL, 32'h1);
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (busy);
    chk(32'(n), {27'h0, t});
    rd(REG_STAT);
    chk(d, {19'h0, t, 8'h02});
  endtask : run

  task automatic finish_test();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    u_nrbt_mem_model.mem[16'h5000] = 8'h31;
    u_nrbt_mem_model.mem[16'h0ffe] = 8'h40;
    u_nrbt_mem_model.mem[16'h2004] = 8'hbf;
    // Rotates, the first with half, subtract and carry set beforehand
    wr(REG_PTR, 32'h5000);
    wr(REG_AF, 32'h7a13);
    run(32'h6fed, 5'h12);
    rd(REG_AF);
    chk(d, 32'h7301);
    chk({24'h0, u_nrbt_mem_model.mem[16'h5000]}, 32'h1a);
    u_nrbt_mem_model.mem[16'h5000] = 8'h20;
    wr(REG_AF, 32'h8400);
    run(32'h67ed, 5'h12);
    rd(REG_AF);
    chk(d, 32'h8080);
    chk({24'h0, u_nrbt_mem_model.mem[16'h5000]}, 32'h42);
    u_nrbt_mem_model.mem[16'h5000] = 8'h05;
    wr(REG_AF, 32'h0001);
    run(32'h6fed, 5'h12);
    rd(REG_AF);
    chk(d, 32'h0045);
    // Every register and bit code, the pointer form among them
    u_nrbt_mem_model.mem[16'h5000] = 8'h69;
    wr(REG_BC, 32'ha55a);
    wr(REG_DE, 32'h3cc3);
    wr(REG_AF, 32'h9603);
    wc = u_nrbt_mem_model.wr_count;
    for (int r = 0; r < 8; r++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        run({16'h0, 2'b01, 3'(b), 3'(r), OPC_BITPFX}, (r == 6) ? 5'h0c : 5'h08);
        rd(REG_AF);
        chk(d, {16'h0, 8'h96, 1'b0, !opnd[r][b], 6'h11});
      end
    end
    rd(REG_BC);
    chk(d, 32'ha55a);
    rd(REG_DE);
    chk(d, 32'h3cc3);
    chk(32'(u_nrbt_mem_model.wr_count - wc), 32'h0);
    // Index forms: negative displacement on the first pair
    wr(REG_IDX1, 32'h1000);
    wr(REG_IDX2, 32'h2000);
    run({8'h76, 8'hfe, OPC_BITPFX, OPC_IDX1}, 5'h14);
    rd(REG_AF);
    chk(d, 32'h9611);
    run({8'h76, 8'h04, OPC_BITPFX, OPC_IDX2}, 5'h14);
    rd(REG_AF);
    chk(d, 32'h9651);
    // Unmapped register
    rd(8'h24);
    chk(d, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h24, 32'h1);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    // Refused code: no run, status flags it, registers keep their values
    wr(REG_INSTR, 32'h00ed);
    wr(REG_CTRL, 32'h1);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rd(REG_STAT);
    chk(d, 32'h1406);
    rd(REG_AF);
    chk(d, 32'h9651);
    finish_test();
  end
endmodule : testbench
